// file: verilog/shs_defines.svh
`ifndef SHS_DEFINES_SVH
`define SHS_DEFINES_SVH

// register indices; byte address is four times the index
`define SHS_IDX_STATUS 16'hF703
`define SHS_IDX_IRQEN 16'hF704
`define SHS_IDX_COUNT 16'hF706
`define SHS_IDX_COMPARE 16'hF708
`define SHS_IDX_IRQCLR 16'hF710
`define SHS_IDX_MODE 16'hF712
`define SHS_IDX_MODECNT 16'hF714
`define SHS_IDX_COUNT1 16'hF716
`define SHS_IDX_SEQSTAT 16'hF718
`define SHS_IDX_RUN 16'hF720
`define SHS_IDX_LOCK 16'hF721
`define SHS_IDX_COMB 16'hF723
`define SHS_IDX_OUTEN 16'hF724
`define SHS_IDX_INITLVL 16'hF725
`define SHS_IDX_PDATA 16'hFFD9
`define SHS_IDX_PDIR 16'hFFE9

// field positions
`define SHS_BIT_RUN0 0
`define SHS_BIT_RUN1 1
`define SHS_BIT_SYNC 0
`define SHS_BIT_DIS0 0
`define SHS_BIT_LVL0 0
`define SHS_EV_MATCH 0
`define SHS_EV_MODE 1
`define SHS_EV_W 2

// reset values
`define SHS_RST_PDATA 8'h08
`define SHS_RST_PDIR 8'h00
`define SHS_RST_OUTEN 8'h01
`define SHS_RST_COMPARE 16'hFFFF
`define SHS_RST_MODECNT 16'h0000
`define SHS_TBL_LAST 7'h5F

`endif

// file: verilog/shs_pkg.sv
package shs_pkg;

  typedef enum logic [2:0] {
    MODE_FWD_UP,
    MODE_FWD_DOWN,
    MODE_FWD_CONST,
    MODE_STOP,
    MODE_REV_UP,
    MODE_REV_DOWN,
    MODE_REV_CONST
  } shs_mode_e;

  localparam logic [0:7][7:0] SHS_PATTERN = {
    8'h08, 8'h0C, 8'h04, 8'h06, 8'h02, 8'h03, 8'h01, 8'h09
  };

  localparam logic [0:95][15:0] SHS_INTERVAL = {
    16'hFFFF, 16'hF000, 16'hE000, 16'hD500, 16'hCE40, 16'hC738, 16'hC030, 16'hB928,
    16'hB220, 16'hAB18, 16'hA410, 16'h9DD0, 16'h9790, 16'h9150, 16'h8CA0, 16'h87F0,
    16'h8340, 16'h8020, 16'h7D00, 16'h7AA8, 16'h7850, 16'h75F8, 16'h74BD, 16'h7148,
    16'h6FB8, 16'h6E28, 16'h6C98, 16'h6B08, 16'h6978, 16'h67E8, 16'h66BC, 16'h6590,
    16'h6464, 16'h6338, 16'h620C, 16'h6144, 16'h607C, 16'h5FB4, 16'h5EEC, 16'h5DCA,
    16'h5CA8, 16'h5B86, 16'h5A64, 16'h5942, 16'h5820, 16'h56FE, 16'h55DC, 16'h54BA,
    16'h5398, 16'h5276, 16'h5154, 16'h5032, 16'h4F10, 16'h4DEE, 16'h4CCC, 16'h4BAA,
    16'h4A88, 16'h4966, 16'h4844, 16'h4722, 16'h4600, 16'h44DE, 16'h43BC, 16'h429A,
    16'h4178, 16'h4056, 16'h3F34, 16'h3E12, 16'h3CF0, 16'h3BC4, 16'h3A34, 16'h3890,
    16'h373C, 16'h35E8, 16'h3494, 16'h33D6, 16'h3318, 16'h325A, 16'h319C, 16'h30DE,
    16'h3064, 16'h2FEA, 16'h2F70, 16'h2EF6, 16'h2E7C, 16'h2E02, 16'h2D9C, 16'h2D36,
    16'h2CD0, 16'h2C6A, 16'h2C04, 16'h2B9E, 16'h2B38, 16'h2AD2, 16'h2A6C, 16'h2A00
  };

endpackage

// file: verilog/shs_sequencer.sv
// What this block does
// - Step counter counts only while the run bit is set; clearing it holds count.
// - Lockstep bit set with combination field zero: second counter tracks step counter; clear: independent.
// - Combination field zero keeps both channels in normal operation.
// - Compare output disable bit is active low enable: 0 drives pin, 1 releases.
// - Initial level bit sets compare pin level before any compare match.
// - Phase direction bits set to one make the phase lines outputs.
// - Phase data bits drive phases directly; reset value excites phase A only.
// - Phase output walks the eight entry half-step pattern 08,0C,04,06,02,03,01,09.
// - Bit 3 is A, bit 2 is B, bit 1 is A-bar, bit 0 is B-bar.
// - During slews each step loads the next interval entry into the compare.
// - Interval table holds 96 values falling from FFFF to 2A00.
// - Seven modes: forward and reverse slew-up, slew-down, constant, plus stop.
// - Mode selector holds the mode; a step count sets how long it lasts.
// - Compare match flag sets when counter equals compare while the run bit is set; live bit shows that match.
// - Match interrupt enable passes or suppresses the match flag interrupt.
`timescale 1ns/1ps
`default_nettype none
`include "shs_defines.svh"

module shs_sequencer
  import shs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [19:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [19:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic phase_a_line,
  output logic phase_a_line_oe_n,
  output logic phase_b_line,
  output logic phase_b_line_oe_n,
  output logic phase_a_bar_line,
  output logic phase_a_bar_line_oe_n,
  output logic phase_b_bar_line,
  output logic phase_b_bar_line_oe_n,
  output logic compare_output_pin,
  output logic compare_output_pin_oe_n,
  output logic irq
);

  logic aw_full, w_full;
  logic [19:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_en;
  logic [15:0] wr_idx;
  logic [31:0] rd_val;
  logic [7:0] run_ctrl, lock_mode, comb_func, out_en, init_lvl, pdata, pdir;
  logic [15:0] step_counter, second_channel_counter, step_compare_value, mode_count;
  logic [`SHS_EV_W-1:0] status, irq_en;
  shs_mode_e mode, next_mode;
  logic [2:0] pat_idx;
  logic [6:0] tbl_idx;
  logic counter_run_bit, lockstep, comb_normal, match, step, mode_done, fwd;
  logic [`SHS_EV_W-1:0] events;
  logic [3:0] phase_vec, phase_oe_n;

  function automatic logic mapped(input logic [19:0] a);
    logic hit;
    hit = 1'b0;
    if (a[19:18] == 2'h0 && a[1:0] == 2'h0) begin
      case (a[17:2])
        `SHS_IDX_STATUS, `SHS_IDX_IRQEN, `SHS_IDX_COUNT, `SHS_IDX_COMPARE,
        `SHS_IDX_IRQCLR, `SHS_IDX_MODE, `SHS_IDX_MODECNT, `SHS_IDX_COUNT1,
        `SHS_IDX_SEQSTAT, `SHS_IDX_RUN, `SHS_IDX_LOCK, `SHS_IDX_COMB,
        `SHS_IDX_OUTEN, `SHS_IDX_INITLVL, `SHS_IDX_PDATA, `SHS_IDX_PDIR: hit = 1'b1;
        default: hit = 1'b0;
      endcase
    end
    return hit;
  endfunction

  function automatic shs_mode_e to_mode(input logic [2:0] v);
    // the unused code falls back to stop so the motor never runs on garbage
    return (v == 3'h7) ? MODE_STOP : shs_mode_e'(v);
  endfunction

  // AXI4-Lite write side: address and data held independently until both are in
  assign s_axi_awready = !aw_full;
  assign s_axi_wready = !w_full;
  assign wr_en = aw_full && w_full && !s_axi_bvalid;
  assign wr_idx = aw_addr[17:2];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 20'h00000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && !aw_full) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_en) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read side: one outstanding read, data registered one edge after the address
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rd_val = 32'h00000000;
    case (s_axi_araddr[17:2])
      `SHS_IDX_STATUS: rd_val = {29'h00000000, match, status};
      `SHS_IDX_IRQEN: rd_val = {30'h00000000, irq_en};
      `SHS_IDX_COUNT: rd_val = {16'h0000, step_counter};
      `SHS_IDX_COMPARE: rd_val = {16'h0000, step_compare_value};
      `SHS_IDX_MODE: rd_val = {25'h0000000, next_mode, 1'b0, mode};
      `SHS_IDX_MODECNT: rd_val = {16'h0000, mode_count};
      `SHS_IDX_COUNT1: rd_val = {16'h0000, second_channel_counter};
      `SHS_IDX_SEQSTAT: rd_val = {21'h000000, tbl_idx, 1'b0, pat_idx};
      `SHS_IDX_RUN: rd_val = {24'h000000, run_ctrl};
      `SHS_IDX_LOCK: rd_val = {24'h000000, lock_mode};
      `SHS_IDX_COMB: rd_val = {24'h000000, comb_func};
      `SHS_IDX_OUTEN: rd_val = {24'h000000, out_en};
      `SHS_IDX_INITLVL: rd_val = {24'h000000, init_lvl};
      `SHS_IDX_PDATA: rd_val = {24'h000000, pdata};
      `SHS_IDX_PDIR: rd_val = {24'h000000, pdir};
      default: rd_val = 32'h00000000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= mapped(s_axi_araddr) ? rd_val : 32'h00000000;
      s_axi_rresp <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // plain byte-wide control registers, plus the two-bit irq_en
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_ctrl <= 8'h00;
      lock_mode <= 8'h00;
      comb_func <= 8'h00;
      out_en <= `SHS_RST_OUTEN;
      init_lvl <= 8'h00;
      pdir <= `SHS_RST_PDIR;
      irq_en <= '0;
    end else if (wr_en && w_strb[0]) begin
      case (wr_idx)
        `SHS_IDX_RUN: run_ctrl <= w_data[7:0];
        `SHS_IDX_LOCK: lock_mode <= w_data[7:0];
        `SHS_IDX_COMB: comb_func <= w_data[7:0];
        `SHS_IDX_OUTEN: out_en <= w_data[7:0];
        `SHS_IDX_INITLVL: init_lvl <= w_data[7:0];
        `SHS_IDX_PDIR: pdir <= w_data[7:0];
        `SHS_IDX_IRQEN: irq_en <= w_data[`SHS_EV_W-1:0];
        default: ;
      endcase
    end
  end

  assign counter_run_bit = run_ctrl[`SHS_BIT_RUN0];
  assign comb_normal = (comb_func[1:0] == 2'h0);
  assign lockstep = lock_mode[`SHS_BIT_SYNC] && comb_normal;
  assign match = counter_run_bit && (step_counter == step_compare_value);
  assign step = match && (mode != MODE_STOP);
  assign mode_done = match && (mode_count == 16'h0001);
  assign fwd = (mode == MODE_FWD_UP) || (mode == MODE_FWD_DOWN) || (mode == MODE_FWD_CONST);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_counter <= 16'h0000;
    end else if (match) begin
      step_counter <= 16'h0000;
    end else if (wr_en && wr_idx == `SHS_IDX_COUNT && w_strb[1:0] == 2'h3) begin
      step_counter <= w_data[15:0];
    end else if (counter_run_bit) begin
      step_counter <= step_counter + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      second_channel_counter <= 16'h0000;
    end else if (lockstep) begin
      if (match) begin
        second_channel_counter <= 16'h0000;
      end else if (wr_en && wr_idx == `SHS_IDX_COUNT && w_strb[1:0] == 2'h3) begin
        // follow a software load too, or the mirror lags one write behind
        second_channel_counter <= w_data[15:0];
      end else if (counter_run_bit) begin
        second_channel_counter <= step_counter + 16'h0001;
      end else begin
        second_channel_counter <= step_counter;
      end
    end else if (comb_normal && run_ctrl[`SHS_BIT_RUN1]) begin
      second_channel_counter <= second_channel_counter + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_compare_value <= `SHS_RST_COMPARE;
      tbl_idx <= 7'h00;
    end else if (step && (mode == MODE_FWD_UP || mode == MODE_REV_UP)) begin
      step_compare_value <= SHS_INTERVAL[tbl_idx];
      if (tbl_idx != `SHS_TBL_LAST) begin
        tbl_idx <= tbl_idx + 7'h01;
      end
    end else if (step && (mode == MODE_FWD_DOWN || mode == MODE_REV_DOWN)) begin
      step_compare_value <= SHS_INTERVAL[tbl_idx];
      if (tbl_idx != 7'h00) begin
        tbl_idx <= tbl_idx - 7'h01;
      end
    end else if (wr_en && wr_idx == `SHS_IDX_COMPARE && w_strb[1:0] == 2'h3) begin
      step_compare_value <= w_data[15:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pat_idx <= 3'h0;
      pdata <= `SHS_RST_PDATA;
    end else if (step) begin
      pat_idx <= fwd ? pat_idx + 3'h1 : pat_idx - 3'h1;
      pdata <= SHS_PATTERN[fwd ? pat_idx + 3'h1 : pat_idx - 3'h1];
    end else if (wr_en && wr_idx == `SHS_IDX_PDATA && w_strb[0]) begin
      pdata <= w_data[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= MODE_STOP;
      next_mode <= MODE_STOP;
      mode_count <= `SHS_RST_MODECNT;
    end else begin
      if (mode_done) begin
        mode <= next_mode;
      end else if (wr_en && wr_idx == `SHS_IDX_MODE && w_strb[0]) begin
        mode <= to_mode(w_data[2:0]);
        next_mode <= to_mode(w_data[6:4]);
      end
      if (match && mode_count != 16'h0000) begin
        mode_count <= mode_count - 16'h0001;
      end else if (wr_en && wr_idx == `SHS_IDX_MODECNT && w_strb[1:0] == 2'h3) begin
        mode_count <= w_data[15:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_output_pin <= 1'b0;
    end else if (!counter_run_bit) begin
      compare_output_pin <= init_lvl[`SHS_BIT_LVL0];
    end else if (match) begin
      compare_output_pin <= !compare_output_pin;
    end
  end

  assign compare_output_pin_oe_n = out_en[`SHS_BIT_DIS0];

  // sticky events; a set in the same cycle as a clear wins
  assign events = {mode_done, match};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= '0;
    end else if (wr_en && wr_idx == `SHS_IDX_IRQCLR && w_strb[0]) begin
      status <= (status & ~w_data[`SHS_EV_W-1:0]) | events;
    end else begin
      status <= status | events;
    end
  end

  assign irq = |(status & irq_en);

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_phase
      assign phase_vec[gi] = pdata[gi];
      assign phase_oe_n[gi] = !pdir[gi];
    end
  endgenerate
  assign phase_a_line = phase_vec[3];
  assign phase_b_line = phase_vec[2];
  assign phase_a_bar_line = phase_vec[1];
  assign phase_b_bar_line = phase_vec[0];
  assign phase_a_line_oe_n = phase_oe_n[3];
  assign phase_b_line_oe_n = phase_oe_n[2];
  assign phase_a_bar_line_oe_n = phase_oe_n[1];
  assign phase_b_bar_line_oe_n = phase_oe_n[0];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  run_hold_a: assert property (!counter_run_bit |=> $stable(step_counter)
    || $past(wr_en)) else $error("counter moved while stopped");
  sync_mirror_a: assert property (lockstep |=> second_channel_counter == step_counter)
    else $error("second counter not in lockstep");
  comb_freeze_a: assert property (!comb_normal |=> $stable(second_channel_counter))
    else $error("second counter moved in combined mode");
  init_level_a: assert property (!counter_run_bit ##1 !counter_run_bit
    |-> compare_output_pin == $past(init_lvl[0])) else $error("wrong initial level");
  phase_dir_a: assert property (pdir[3:0] == 4'hF |-> {phase_a_line_oe_n,
    phase_b_bar_line_oe_n} == 2'h0) else $error("phase lines not driven");
  pattern_step_a: assert property (step && fwd |=>
    pdata[3:0] == SHS_PATTERN[$past(pat_idx) + 3'h1][3:0]) else $error("bad pattern");
  slew_load_a: assert property (step && mode == MODE_FWD_UP |=>
    step_compare_value == SHS_INTERVAL[$past(tbl_idx)]) else $error("bad slew load");
  match_flag_a: assert property (match |=> status[0])
    else $error("match flag not set");
  irq_gate_a: assert property (status[0] && irq_en[0] |-> irq)
    else $error("interrupt not raised");
  mode_next_a: assert property (mode_done |=> mode == $past(next_mode))
    else $error("mode not switched");
  counter_clear_a: assert property (match |=> step_counter == 16'h0000 ##1
    (!counter_run_bit || step_counter == 16'h0001)) else $error("counter not cleared");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");

  step_fwd_c: cover property (step && fwd);
  step_rev_c: cover property (step && !fwd);
  mode_switch_c: cover property (mode_done);
  irq_raise_c: cover property ($rose(irq));

endmodule // shs_sequencer

`default_nettype wire

// file: dv/shs_motor_model.sv
`timescale 1ns/1ps
`default_nettype none

module shs_motor_model (
  input wire logic aclk,
  input wire logic [3:0] line,
  input wire logic [3:0] line_oe_n,
  output logic [3:0] coil,
  output int steps,
  output int faults
);
  logic [3:0] last;
  int d;

  function automatic int pos(input logic [3:0] c);
    case (c)
      4'h8: return 0;
      4'hC: return 1;
      4'h4: return 2;
      4'h6: return 3;
      4'h2: return 4;
      4'h3: return 5;
      4'h1: return 6;
      4'h9: return 7;
      default: return 99;
    endcase
  endfunction

  // bit 3 A, 2 B, 1 A-bar, 0 B-bar
  // released lines fall to the driver board pull-downs
  assign coil = line & ~line_oe_n;

  initial begin
    steps = 0;
    faults = 0;
    last = 4'h0;
  end

  // a coil change is one half step either way
  always @(posedge aclk) begin
    if (coil !== last && last != 4'h0 && coil != 4'h0) begin
      steps = steps + 1;
      d = (pos(coil) - pos(last) + 8) % 8;
      if (pos(coil) > 7 || (d != 1 && d != 7)) begin
        faults = faults + 1;
      end
    end
    last = coil;
  end
endmodule // shs_motor_model

`default_nettype wire

// file: dv/test_stepper_half_step_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "shs_defines.svh"

module test_stepper_half_step_sequencer
  import shs_pkg::*;
;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq, cpin, cpin_oe_n;
  logic [19:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb, ph, oe_n, coil;
  logic [1:0] bresp, rresp, resp;
  logic [15:0] prev, e;
  logic [7:0] pat [8] = '{8'h08, 8'h0C, 8'h04, 8'h06, 8'h02, 8'h03, 8'h01, 8'h09};
  int bad_count, cmp_count, steps, faults;

  shs_sequencer dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .phase_a_line(ph[3]), .phase_a_line_oe_n(oe_n[3]), .phase_b_line(ph[2]),
    .phase_b_line_oe_n(oe_n[2]), .phase_a_bar_line(ph[1]), .phase_a_bar_line_oe_n(oe_n[1]),
    .phase_b_bar_line(ph[0]), .phase_b_bar_line_oe_n(oe_n[0]),
    .compare_output_pin(cpin), .compare_output_pin_oe_n(cpin_oe_n), .irq(irq));

  shs_motor_model motor_u (.aclk(aclk), .line(ph), .line_oe_n(oe_n), .coil(coil),
    .steps(steps), .faults(faults));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic end_of_test;
    $display("counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hung(input int n);
    if (n >= 200) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, n, 0);
      end_of_test();
    end
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    int n;
    logic a, w;
    @(posedge aclk);
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    a = 1'b0;
    w = 1'b0;
    n = 0;
    while (!(a && w) && n < 200) begin
      @(posedge aclk);
      n++;
      if (!a && awready) begin
        a = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge aclk);
      n++;
    end while (!bvalid && n < 200);
    resp = bresp;
    bready <= 1'b0;
    hung(n);
  endtask

  task automatic rd(input logic [15:0] idx, output logic [31:0] d);
    int n;
    @(posedge aclk);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!arready && n < 200);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (!rvalid && n < 200);
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
    hung(n);
  endtask

  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 200) begin
      @(posedge aclk);
      n++;
    end
    hung(n);
  endtask

  // mode register word: next mode in [6:4], mode in [2:0]
  function automatic logic [31:0] mw(input shs_mode_e nx, input shs_mode_e m);
    return {25'h0, nx, 1'b0, m};
  endfunction

  initial begin
    aresetn <= 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
    {awaddr, araddr, wdata} <= '0;
    wstrb <= 4'hF;
    bad_count = 0;
    cmp_count = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`SHS_IDX_PDATA, v);
    chk(v, 32'h08);
    rd(`SHS_IDX_OUTEN, v);
    chk(v, 32'h01);
    rd(`SHS_IDX_COMPARE, v);
    chk(v, 32'hFFFF);
    rd(16'h0100, v);
    chk(v, 32'h0);
    chk(resp, 32'h2);
    wr(16'h0100, 32'h5A);
    chk(resp, 32'h2);
    chk({oe_n, cpin_oe_n}, 5'h1F);
    wr(`SHS_IDX_PDIR, 32'h0F);
    chk({oe_n, coil, ph[3]}, 9'h011);
    wr(`SHS_IDX_OUTEN, 32'h00);
    wr(`SHS_IDX_INITLVL, 32'h01);
    // the pin takes the new level one edge after the register
    @(posedge aclk);
    chk({cpin_oe_n, cpin}, 2'b01);
    $display("test pins done");
    wr(`SHS_IDX_COUNT, 32'h1234);
    wr(`SHS_IDX_LOCK, 32'h01);
    rd(`SHS_IDX_COUNT1, v);
    chk(v, 32'h1234);
    wr(`SHS_IDX_LOCK, 32'h00);
    wr(`SHS_IDX_COUNT, 32'h0055);
    rd(`SHS_IDX_COUNT1, v);
    chk(v, 32'h1234);
    wr(`SHS_IDX_COMB, 32'h01);
    wr(`SHS_IDX_RUN, 32'h2);
    rd(`SHS_IDX_COUNT1, v);
    chk(v, 32'h1234);
    wr(`SHS_IDX_COMB, 32'h00);
    rd(`SHS_IDX_COUNT1, v);
    chk({31'h0, v != 32'h1234}, 32'h1);
    rd(`SHS_IDX_COUNT, v);
    chk(v, 32'h0055);
    wr(`SHS_IDX_RUN, 32'h0);
    rd(`SHS_IDX_COMB, v);
    chk(v, 32'h00);
    $display("test counters done");
    wr(`SHS_IDX_COMPARE, 32'h3F);
    wr(`SHS_IDX_COUNT, 32'h0);
    wr(`SHS_IDX_IRQEN, 32'h1);
    wr(`SHS_IDX_MODECNT, 32'h8);
    wr(`SHS_IDX_MODE, mw(MODE_STOP, MODE_FWD_CONST));
    wr(`SHS_IDX_RUN, 32'h1);
    rd(`SHS_IDX_COUNT, v);
    chk({31'h0, v != 32'h0}, 32'h1);
    for (int k = 0; k < 8; k++) begin
      wait_irq();
      chk(coil, pat[(k + 1) % 8]);
      wr(`SHS_IDX_IRQCLR, 32'h1);
    end
    rd(`SHS_IDX_MODE, v);
    chk(v & 32'h7, 32'h3);
    rd(`SHS_IDX_STATUS, v);
    chk(v & 32'h2, 32'h2);
    rd(`SHS_IDX_COMPARE, v);
    chk(v, 32'h3F);
    wait_irq();
    chk(coil, 32'h08);
    wr(`SHS_IDX_IRQEN, 32'h0);
    wr(`SHS_IDX_IRQCLR, 32'h3);
    repeat (70) @(posedge aclk);
    chk(irq, 1'b0);
    rd(`SHS_IDX_STATUS, v);
    chk(v & 32'h1, 32'h1);
    wr(`SHS_IDX_IRQEN, 32'h1);
    chk(irq, 1'b1);
    $display("test constant and stop done");
    wr(`SHS_IDX_RUN, 32'h0);
    wr(`SHS_IDX_MODECNT, 32'h0);
    wr(`SHS_IDX_MODE, mw(MODE_STOP, MODE_REV_CONST));
    wr(`SHS_IDX_COUNT, 32'h0);
    wr(`SHS_IDX_IRQCLR, 32'h3);
    wr(`SHS_IDX_RUN, 32'h1);
    for (int k = 0; k < 3; k++) begin
      wait_irq();
      chk(coil, pat[7 - k]);
      wr(`SHS_IDX_IRQCLR, 32'h1);
    end
    $display("test reverse done");
    wr(`SHS_IDX_RUN, 32'h0);
    wr(`SHS_IDX_MODE, mw(MODE_STOP, MODE_FWD_UP));
    wr(`SHS_IDX_COUNT, 32'h30);
    wr(`SHS_IDX_IRQCLR, 32'h3);
    wr(`SHS_IDX_RUN, 32'h1);
    prev = 16'hFFFF;
    for (int i = 0; i < 100; i++) begin
      wait_irq();
      rd(`SHS_IDX_COMPARE, v);
      e = (i < 97) ? SHS_INTERVAL[(i > 95) ? 95 : i] : SHS_INTERVAL[95 - (i - 97)];
      if (i == 0) e = 16'hFFFF;
      if (i == 95) e = 16'h2A00;
      chk(v, {16'h0, e});
      if (i > 0 && i < 96) chk({31'h0, v[15:0] < prev}, 32'h1);
      prev = v[15:0];
      // park the counter just short of the new interval to keep the run short
      wr(`SHS_IDX_RUN, 32'h0);
      wr(`SHS_IDX_COUNT, v - 32'h8);
      if (i == 96) wr(`SHS_IDX_MODE, mw(MODE_STOP, MODE_FWD_DOWN));
      wr(`SHS_IDX_IRQCLR, 32'h1);
      wr(`SHS_IDX_RUN, 32'h1);
    end
    $display("test slew done");
    // reverse slews from table entry 92; the last count run stops four short of a match
    wr(`SHS_IDX_RUN, 32'h0);
    wr(`SHS_IDX_MODE, mw(MODE_REV_DOWN, MODE_REV_UP));
    wr(`SHS_IDX_MODECNT, 32'h1);
    wr(`SHS_IDX_COUNT, 32'h0);
    wr(`SHS_IDX_COMPARE, 32'h20);
    wr(`SHS_IDX_IRQCLR, 32'h3);
    wr(`SHS_IDX_RUN, 32'h1);
    for (int k = 0; k < 2; k++) begin
      wait_irq();
      chk(coil, pat[7 * k]);
      rd(`SHS_IDX_MODE, v);
      chk(v & 32'h7, 32'h5);
      rd(`SHS_IDX_COMPARE, v);
      chk(v, {16'h0, SHS_INTERVAL[92 + k]});
      wr(`SHS_IDX_RUN, 32'h0);
      wr(`SHS_IDX_COUNT, v - 32'h8);
      wr(`SHS_IDX_IRQCLR, 32'h1);
      wr(`SHS_IDX_RUN, 32'h1);
    end
    wr(`SHS_IDX_RUN, 32'h0);
    wr(`SHS_IDX_MODE, 32'h7);
    rd(`SHS_IDX_MODE, v);
    chk(v & 32'h77, 32'h03);
    $display("test reverse slew done");
    chk(faults, 32'h0);
    chk(steps, 32'd113);
    end_of_test();
  end
endmodule // test_stepper_half_step_sequencer

`default_nettype wire
